// ===== inc/tsm_pkg.sv
// Constants, field layouts and carrier types for the TDM slot channel map.
// Assumes an AXI4-Lite master on aclk and a framed serial link on its own clock.
// Overview of operation
// - One 16-bit table entry per 8-bit slot
// - Invalid receive slot: bits discarded, nothing stored
// - Valid receive slot: bits passed to channel
// - Receive wrap entry: idle until frame sync, restart
// - Receive channel address: pointer, six low zeros
// - Transmit channel address: pointer, six low zeros
// - Receive mask zero bits still delivered, mask passed with data, no counting
// - Invalid transmit slot drives logic one
// - Valid transmit slot sends channel buffer data
// - Transmit wrap entry: idle until frame sync, restart at start entry
// - Transmit mask zero positions drive logic high
// - Equal start pointers share one common table
// - Table holds up to 64 entries
// - Tables located only by start pointers
// - Current transmit pointer advances every slot while transmit is active

package tsm_pkg;

   localparam int TBL_DEPTH   = 64;
   localparam int IDX_W       = 6;
   localparam int ADDR_W      = 12;
   localparam int SLOT_BITS   = 8;
   localparam int ENTRY_W     = 16;
   localparam int CHAN_ADDR_W = 12;

   localparam logic [ADDR_W-1:0] OFS_CTRL      = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_RX_START  = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_TX_START  = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_TX_CUR    = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_TABLE     = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_TABLE_END = 12'h11c;

   localparam int CTRL_RX_EN = 0;
   localparam int CTRL_TX_EN = 1;

   localparam int ENT_VALID   = 15;
   localparam int ENT_WRAP    = 14;
   localparam int ENT_M0      = 13;
   localparam int ENT_M1      = 12;
   localparam int ENT_PTR_MSB = 11;
   localparam int ENT_PTR_LSB = 6;
   localparam int ENT_MLO_MSB = 5;

   localparam logic [5:0]             CHAN_LOW_ZERO = 6'h00;
   localparam logic [IDX_W-1:0]       IDX_ONE       = 6'h01;
   localparam logic [2:0]             BIT_LAST      = 3'h7;
   localparam logic [1:0]             RESP_OKAY     = 2'h0;
   localparam logic [1:0]             RESP_SLVERR   = 2'h2;
   localparam logic [ENTRY_W-1:0]     ENTRY_RESET   = 16'h0000;

   typedef struct packed {
      logic [CHAN_ADDR_W-1:0] addr;
      logic [SLOT_BITS-1:0]   mask;
      logic [SLOT_BITS-1:0]   data;
   } tsm_rx_t;

   typedef struct packed {
      logic [CHAN_ADDR_W-1:0] addr;
      logic [SLOT_BITS-1:0]   mask;
      logic [IDX_W-1:0]       tag;
   } tsm_req_t;

   typedef struct packed {
      logic [SLOT_BITS-1:0] data;
      logic [IDX_W-1:0]     tag;
   } tsm_resp_t;

   typedef struct packed {
      logic             rx_en;
      logic             tx_en;
      logic [IDX_W-1:0] rx_start;
      logic [IDX_W-1:0] tx_start;
      logic             tx_load;
      logic [IDX_W-1:0] tx_cur;
   } tsm_cfg_t;

   typedef struct packed {
      logic [IDX_W-1:0] rx_idx;
      logic [IDX_W-1:0] tx_idx;
   } tsm_snap_t;

   function automatic logic [SLOT_BITS-1:0] entry_mask(input logic [ENTRY_W-1:0] e);
      logic [SLOT_BITS-1:0] m;
      m = '0;
      m[0] = e[ENT_M0];
      m[1] = e[ENT_M1];
      for (int k = 0; k < SLOT_BITS - 2; k++) begin
         m[k+2] = e[ENT_MLO_MSB-k];
      end
      return m;
   endfunction : entry_mask

   function automatic logic [CHAN_ADDR_W-1:0] chan_addr(input logic [ENTRY_W-1:0] e);
      return {e[ENT_PTR_MSB:ENT_PTR_LSB], CHAN_LOW_ZERO};
   endfunction : chan_addr

endpackage : tsm_pkg

// ===== src/tsm_slot_map.sv
// Slot channel map: AXI4-Lite register file, mapping table and both link directions.
// Assumes a free-running link clock while enabled and configuration writes spaced apart.
`timescale 1ns/100ps
`default_nettype none

module tsm_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : tsm_sync2

module tsm_slot_map
   import tsm_pkg::*;
(
   // Register bus clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Serial link
   input  wire logic              link_clk,
   input  wire logic              link_sync,
   input  wire logic              link_rx,
   output logic                   link_tx,
   // Channel processing side
   output logic                   rx_valid,
   output tsm_rx_t                rx_word,
   output logic                   tx_req_valid,
   output tsm_req_t               tx_req,
   input  wire logic              tx_req_ready,
   input  wire logic [7:0]        tx_byte
);

   logic [ENTRY_W-1:0] tbl_q [TBL_DEPTH];

   // Bus side state.
   logic              aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       wdata_q, rdata_q, rd_data_d;
   logic [3:0]        wstrb_q;
   logic [1:0]        bresp_q, rresp_q;
   logic              wr_go, rd_ok_d, wr_ok;
   logic [ADDR_W-1:0] wa, ra;
   tsm_cfg_t          cfg_q;
   logic              cfg_tog_q, resp_tog_q, tx_req_valid_q, rx_valid_q;
   tsm_resp_t         resp_hold_q;
   tsm_req_t          tx_req_q;
   tsm_rx_t           rx_word_q;
   tsm_snap_t         snap_q;
   logic [2:0]        a_tog_s, a_tog_prev_q, a_edge;

   // Link side state.
   logic              lrst_n;
   logic [1:0]        pin_s, l_tog_s, l_tog_prev_q;
   logic              sync_s, rxd_s, cfg_edge, resp_edge;
   tsm_cfg_t          cfg_l_q;
   logic [2:0]        bit_q, cur_bit;
   logic              slot_end;
   logic [IDX_W-1:0]  rx_idx_q, rx_idx_c, tx_idx_q, tx_idx_c, tx_nxt;
   logic              rx_act_q, rx_act_c, tx_act_q, tx_act_c;
   logic [ENTRY_W-1:0] rx_ent, tx_ent;
   logic [SLOT_BITS-1:0] tx_mask;
   logic [SLOT_BITS-1:0] rx_sh_q, rx_data_c;
   tsm_rx_t           rx_hold_q;
   logic              rx_tog_q, req_tog_q, snap_tog_q, prime_q, txd_ok_q, link_tx_q;
   tsm_req_t          req_hold_q;
   tsm_resp_t         txd_q;
   tsm_snap_t         snap_hold_q;

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready  = !w_have_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign wr_go         = aw_have_q && w_have_q && !bvalid_q;
   assign wa            = {aw_addr_q[ADDR_W-1:2], 2'b00};
   assign ra            = {s_axi_araddr[ADDR_W-1:2], 2'b00};
   assign wr_ok         = (wa <= OFS_STATUS) || (wa >= OFS_TABLE && wa <= OFS_TABLE_END);

   // Address and data are latched independently, so either may arrive first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Status is read-only; a write to it is accepted and ignored.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q     <= '0;
         cfg_tog_q <= 1'b0;
      end else if (wr_go && wstrb_q[0] && wa < OFS_STATUS) begin
         cfg_tog_q <= !cfg_tog_q;
         cfg_q.tx_load <= (wa == OFS_TX_CUR);
         if (wa == OFS_CTRL) begin
            cfg_q.rx_en <= wdata_q[CTRL_RX_EN];
            cfg_q.tx_en <= wdata_q[CTRL_TX_EN];
         end else if (wa == OFS_RX_START) begin
            cfg_q.rx_start <= wdata_q[IDX_W-1:0];
         end else if (wa == OFS_TX_START) begin
            cfg_q.tx_start <= wdata_q[IDX_W-1:0];
         end else begin
            cfg_q.tx_cur <= wdata_q[IDX_W-1:0];
         end
      end
   end

   // Entries are one word each; only the low two byte lanes hold data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < TBL_DEPTH; i++) begin
            tbl_q[i] <= ENTRY_RESET;
         end
      end else if (wr_go && wa >= OFS_TABLE && wa <= OFS_TABLE_END) begin
         for (int b = 0; b < 2; b++) begin
            if (wstrb_q[b]) begin
               tbl_q[IDX_W'((wa - OFS_TABLE) >> 2)][b*8 +: 8] <= wdata_q[b*8 +: 8];
            end
         end
      end
   end

   always_comb begin
      rd_data_d = '0;
      rd_ok_d   = 1'b1;
      if (ra == OFS_CTRL) begin
         rd_data_d[CTRL_RX_EN] = cfg_q.rx_en;
         rd_data_d[CTRL_TX_EN] = cfg_q.tx_en;
      end else if (ra == OFS_RX_START) begin
         rd_data_d[IDX_W-1:0] = cfg_q.rx_start;
      end else if (ra == OFS_TX_START) begin
         rd_data_d[IDX_W-1:0] = cfg_q.tx_start;
      end else if (ra == OFS_TX_CUR) begin
         rd_data_d[IDX_W-1:0] = snap_q.tx_idx;
      end else if (ra == OFS_STATUS) begin
         rd_data_d[IDX_W-1:0] = snap_q.rx_idx;
      end else if (ra >= OFS_TABLE && ra <= OFS_TABLE_END) begin
         rd_data_d[ENTRY_W-1:0] = tbl_q[IDX_W'((ra - OFS_TABLE) >> 2)];
      end else begin
         rd_ok_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_data_d;
         rresp_q  <= rd_ok_d ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Toggles from the link: receive word, transmit request, index snapshot.
   tsm_sync2 #(.W(3)) u_a_sync (
      .clk   (aclk),
      .rst_n (aresetn),
      .d     ({snap_tog_q, req_tog_q, rx_tog_q}),
      .q     (a_tog_s)
   );

   assign a_edge = a_tog_s ^ a_tog_prev_q;

   // Held link words are stable for a whole slot, far longer than the crossing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_tog_prev_q <= '0;
         rx_valid_q   <= 1'b0;
         rx_word_q    <= '0;
         snap_q       <= '0;
      end else begin
         a_tog_prev_q <= a_tog_s;
         rx_valid_q   <= a_edge[0];
         if (a_edge[0]) begin
            rx_word_q <= rx_hold_q;
         end
         if (a_edge[2]) begin
            snap_q <= snap_hold_q;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_req_valid_q <= 1'b0;
         tx_req_q       <= '0;
         resp_hold_q    <= '0;
         resp_tog_q     <= 1'b0;
      end else if (a_edge[1]) begin
         tx_req_valid_q <= 1'b1;
         tx_req_q       <= req_hold_q;
      end else if (tx_req_valid_q && tx_req_ready) begin
         tx_req_valid_q <= 1'b0;
         resp_hold_q    <= '{data: tx_byte, tag: tx_req_q.tag};
         resp_tog_q     <= !resp_tog_q;
      end
   end

   assign rx_valid     = rx_valid_q;
   assign rx_word      = rx_word_q;
   assign tx_req_valid = tx_req_valid_q;
   assign tx_req       = tx_req_q;

   // Link domain.
   tsm_sync2 #(.W(1)) u_l_rst (
      .clk   (link_clk),
      .rst_n (1'b1),
      .d     (aresetn),
      .q     (lrst_n)
   );

   // Both pins take the same two-stage delay, so frame alignment is kept.
   tsm_sync2 #(.W(2)) u_l_pins (
      .clk   (link_clk),
      .rst_n (lrst_n),
      .d     ({link_sync, link_rx}),
      .q     (pin_s)
   );

   tsm_sync2 #(.W(2)) u_l_tog (
      .clk   (link_clk),
      .rst_n (lrst_n),
      .d     ({resp_tog_q, cfg_tog_q}),
      .q     (l_tog_s)
   );

   assign sync_s    = pin_s[1];
   assign rxd_s     = pin_s[0];
   assign cfg_edge  = l_tog_s[0] ^ l_tog_prev_q[0];
   assign resp_edge = l_tog_s[1] ^ l_tog_prev_q[1];
   assign cur_bit   = sync_s ? 3'h0 : bit_q;
   assign slot_end  = (cur_bit == BIT_LAST);
   assign rx_idx_c  = sync_s ? cfg_l_q.rx_start : rx_idx_q;
   assign tx_idx_c  = sync_s ? cfg_l_q.tx_start : tx_idx_q;
   assign rx_act_c  = cfg_l_q.rx_en && (sync_s || rx_act_q);
   assign tx_act_c  = cfg_l_q.tx_en && (sync_s || tx_act_q);
   assign rx_ent    = tbl_q[rx_idx_c];
   assign tx_ent    = tbl_q[tx_idx_c];
   assign tx_nxt    = tx_ent[ENT_WRAP] ? cfg_l_q.tx_start : tx_idx_c + IDX_ONE;
   assign tx_mask   = entry_mask(tx_ent);

   always_comb begin
      rx_data_c          = rx_sh_q;
      rx_data_c[cur_bit] = rxd_s;
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         l_tog_prev_q <= '0;
         cfg_l_q      <= '0;
         bit_q        <= '0;
         txd_q        <= '0;
         txd_ok_q     <= 1'b0;
      end else begin
         l_tog_prev_q <= l_tog_s;
         bit_q        <= cur_bit + 3'h1;
         if (cfg_edge) begin
            cfg_l_q <= cfg_q;
         end
         if (resp_edge) begin
            txd_q    <= resp_hold_q;
            txd_ok_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         rx_sh_q   <= '0;
         rx_idx_q  <= '0;
         rx_act_q  <= 1'b0;
         rx_tog_q  <= 1'b0;
         rx_hold_q <= '0;
      end else begin
         rx_sh_q <= rx_data_c;
         if (slot_end) begin
            if (rx_act_c && rx_ent[ENT_VALID]) begin
               rx_hold_q <= '{addr: chan_addr(rx_ent), mask: entry_mask(rx_ent),
                              data: rx_data_c};
               rx_tog_q  <= !rx_tog_q;
            end
            rx_act_q <= rx_act_c && !rx_ent[ENT_WRAP];
            rx_idx_q <= rx_ent[ENT_WRAP] ? cfg_l_q.rx_start : rx_idx_c + IDX_ONE;
         end else begin
            rx_act_q <= rx_act_c;
            rx_idx_q <= rx_idx_c;
         end
      end
   end

   // A slot whose byte did not arrive in time, or was fetched for another entry, sends ones.
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         link_tx_q <= 1'b1;
         tx_idx_q  <= '0;
         tx_act_q  <= 1'b0;
      end else begin
         if (tx_act_c && tx_ent[ENT_VALID] && tx_mask[cur_bit] && txd_ok_q
             && txd_q.tag == tx_idx_c) begin
            link_tx_q <= txd_q.data[cur_bit];
         end else begin
            link_tx_q <= 1'b1;
         end
         if (cfg_edge && cfg_q.tx_load) begin
            tx_idx_q <= cfg_q.tx_cur;
            tx_act_q <= 1'b0;
         end else if (slot_end) begin
            tx_idx_q <= tx_act_c ? tx_nxt : tx_idx_c;
            tx_act_q <= tx_act_c && !tx_ent[ENT_WRAP];
         end else begin
            tx_idx_q <= tx_idx_c;
            tx_act_q <= tx_act_c;
         end
      end
   end

   // The next slot's byte is fetched one slot ahead to cover both crossings.
   always_ff @(posedge link_clk) begin
      if (!lrst_n) begin
         prime_q     <= 1'b1;
         req_tog_q   <= 1'b0;
         req_hold_q  <= '0;
         snap_tog_q  <= 1'b0;
         snap_hold_q <= '0;
      end else begin
         if (cur_bit == 3'h0 && tx_act_c) begin
            req_hold_q <= '{addr: chan_addr(tbl_q[tx_nxt]), mask: entry_mask(tbl_q[tx_nxt]),
                            tag: tx_nxt};
            req_tog_q  <= !req_tog_q;
         end else if (prime_q && cfg_l_q.tx_en) begin
            req_hold_q <= '{addr: chan_addr(tbl_q[cfg_l_q.tx_start]),
                            mask: entry_mask(tbl_q[cfg_l_q.tx_start]), tag: cfg_l_q.tx_start};
            req_tog_q  <= !req_tog_q;
         end
         if (cfg_edge) begin
            prime_q <= 1'b1;
         end else if (cfg_l_q.tx_en && !(cur_bit == 3'h0 && tx_act_c)) begin
            prime_q <= 1'b0;
         end
         if (slot_end) begin
            snap_hold_q <= '{rx_idx: rx_idx_c, tx_idx: tx_idx_c};
            snap_tog_q  <= !snap_tog_q;
         end
      end
   end

   assign link_tx = link_tx_q;

   a_tx_idle_high: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (tx_act_c && !tx_ent[ENT_VALID]) |=> link_tx)
      else $error("invalid transmit slot did not send one");
   a_tx_mask_high: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (!tx_mask[cur_bit]) |=> link_tx)
      else $error("masked transmit position did not send one");
   a_rx_discard: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (slot_end && !rx_ent[ENT_VALID]) |=> $stable(rx_tog_q))
      else $error("invalid receive slot was delivered");
   a_rx_chan_addr: assert property (@(posedge link_clk) disable iff (!lrst_n)
      $changed(rx_tog_q) |-> rx_hold_q.addr == {$past(rx_ent[ENT_PTR_MSB:ENT_PTR_LSB]), 6'h00})
      else $error("receive channel address wrong");
   a_rx_mask_pass: assert property (@(posedge link_clk) disable iff (!lrst_n)
      $changed(rx_tog_q) |-> rx_hold_q.mask == $past(entry_mask(rx_ent)))
      else $error("receive mask not carried");
   a_rx_wrap_wait: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (slot_end && rx_ent[ENT_WRAP]) ##1 !sync_s [*3] |-> !rx_act_c)
      else $error("receive resumed before frame sync");
   a_sync_restart: assert property (@(posedge link_clk) disable iff (!lrst_n)
      sync_s |=> rx_idx_q == $past(cfg_l_q.rx_start) || $past(slot_end))
      else $error("frame sync did not restart receive table");
   a_tx_advance: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (slot_end && tx_act_c && !tx_ent[ENT_WRAP] && !cfg_edge)
      |=> tx_idx_q == $past(tx_idx_c) + IDX_ONE)
      else $error("transmit pointer did not advance");
   a_tx_wrap_start: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (slot_end && tx_act_c && tx_ent[ENT_WRAP] && !cfg_edge)
      |=> tx_idx_q == $past(cfg_l_q.tx_start))
      else $error("transmit wrap did not return to start");
   a_rx_one_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_valid |=> !rx_valid)
      else $error("receive valid longer than one cycle");

   c_rx_word: cover property (@(posedge aclk) disable iff (!aresetn) rx_valid);
   c_tx_req: cover property (@(posedge aclk) disable iff (!aresetn) tx_req_valid && tx_req_ready);
   c_rx_wrap: cover property (@(posedge link_clk) disable iff (!lrst_n)
      slot_end && rx_act_c && rx_ent[ENT_WRAP]);
   c_tx_data: cover property (@(posedge link_clk) disable iff (!lrst_n) !link_tx);

endmodule : tsm_slot_map

`default_nettype wire

// ===== testbench/tsm_tdm_src.sv
// Far-side model: slot assigner sending framed serial bits.
// Assumes a free-running link clock and a frame of four 8-bit slots.
`timescale 1ns/100ps
`default_nettype none
module tsm_tdm_src (
   // Link
   input  wire logic        link_clk,
   output logic             link_sync,
   output logic             link_rx,
   input  wire logic        link_tx,
   // Control
   input  wire logic        run,
   input  wire logic [31:0] frame,
   output logic [31:0]      tx_seen
);
   logic [4:0] ph_q = 5'h00;
   initial begin
      link_sync = 1'b0;
      link_rx = 1'b1;
      tx_seen = 32'h0;
   end
   // Sync marks bit 0 of slot 0; an idle line toggles so stale bits never look valid.
   always @(posedge link_clk) begin
      link_sync <= run && (ph_q == 5'h00);
      link_rx <= run ? frame[ph_q] : ~link_rx;
      if (run) begin
         ph_q <= ph_q + 5'h01;
      end
   end
   // A sent bit shows three link edges after its slot bit was driven.
   always @(negedge link_clk) begin
      tx_seen[ph_q - 5'h04] <= link_tx;
   end
endmodule : tsm_tdm_src
`default_nettype wire

// ===== testbench/tsm_slot_map_tb_top.sv
// Testbench for the slot channel map: register rows, then a framed link run.
// Assumes the far-side model tsm_tdm_src and a free-running link clock.
`timescale 1ns/100ps
`default_nettype none
module tsm_slot_map_tb_top
   import tsm_pkg::*;
;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] r;} tsm_row_t;
   logic aclk = 1'b0;
   logic link_clk = 1'b0;
   logic aresetn = 1'b0;
   logic run = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_req_ready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rx_valid, tx_req_valid, link_sync, link_rx, link_tx;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, tx_seen, d;
   logic [31:0] frame = 32'h5a963ca5;
   logic [7:0] tx_byte = 8'h00;
   tsm_rx_t rx_word;
   tsm_req_t tx_req;
   tsm_rx_t rxq[$];
   tsm_rx_t rexp[3];
   tsm_row_t rows[14];
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;

   always #2.5 aclk = ~aclk;
   initial begin
      #1.1;
      forever #62.5 link_clk = ~link_clk;
   end

   tsm_slot_map u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .link_sync, .link_rx,
      .link_tx, .rx_valid, .rx_word, .tx_req_valid, .tx_req, .tx_req_ready, .tx_byte);
   tsm_tdm_src u_src (.link_clk, .link_sync, .link_rx, .link_tx, .run, .frame, .tx_seen);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   function automatic logic [31:0] ent(input logic v, input logic w, input logic [5:0] p,
                                       input logic [7:0] m);
      return {16'h0, v, w, m[0], m[1], p, m[2], m[3], m[4], m[5], m[6], m[7]};
   endfunction : ent

   // Readies are sampled at the falling edge, where they hold their pre-edge value.
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ta, tb;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arready;
         tb = s_axi_rvalid;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tb);
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // The channel side answers each byte request one bus cycle after valid, well inside the slot.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      tx_req_ready <= tx_req_valid && !tx_req_ready;
      tx_byte <= ~{2'h0, tx_req.addr[11:6]};
      if (rx_valid) rxq.push_back(rx_word);
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   initial begin
      rows = '{'{1'b0, OFS_CTRL, 32'h0, RESP_OKAY},
               '{1'b0, OFS_TABLE, 32'h0, RESP_OKAY},
               '{1'b1, 12'h024, ent(1'b1, 1'b0, 6'h05, 8'hff), RESP_OKAY},
               '{1'b1, 12'h028, ent(1'b0, 1'b0, 6'h02, 8'hff), RESP_OKAY},
               '{1'b1, 12'h02c, ent(1'b1, 1'b0, 6'h3f, 8'h0f), RESP_OKAY},
               '{1'b1, 12'h030, ent(1'b1, 1'b1, 6'h01, 8'hff), RESP_OKAY},
               '{1'b0, 12'h02c, ent(1'b1, 1'b0, 6'h3f, 8'h0f), RESP_OKAY},
               '{1'b1, 12'h400, 32'h1, RESP_SLVERR},
               '{1'b0, 12'h400, 32'h0, RESP_SLVERR},
               '{1'b0, OFS_TABLE_END, 32'h0, RESP_OKAY},
               '{1'b1, OFS_RX_START, 32'h1, RESP_OKAY},
               '{1'b1, OFS_TX_START, 32'h1, RESP_OKAY},
               '{1'b1, OFS_CTRL, 32'h3, RESP_OKAY},
               '{1'b0, OFS_CTRL, 32'h3, RESP_OKAY}};
      rexp = '{'{12'h140, 8'hff, 8'ha5}, '{12'hfc0, 8'h0f, 8'h96}, '{12'h040, 8'hff, 8'h5a}};
      // Reset spans several link clocks so the link side is cleared too.
      repeat (100) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, r);
         else begin
            axi_rd(rows[i].a, d, r);
            chk(d, rows[i].d);
         end
         chk({30'h0, r}, {30'h0, rows[i].r});
         repeat (130) @(posedge aclk);
      end
      $display("test regs done");
      @(posedge aclk);
      run <= 1'b1;
      repeat (3600) @(posedge aclk);
      chk(tx_seen, 32'hfef0fffa);
      for (int k = 0; k < 3; k++) chk(32'(rxq[k + 3]), 32'(rexp[k]));
      run <= 1'b0;
      $display("test frame done");
      aresetn <= 1'b0;
      repeat (100) @(posedge aclk);
      chk({31'h0, link_tx}, 32'h1);
      chk({31'h0, s_axi_bvalid}, 32'h0);
      aresetn <= 1'b1;
      axi_rd(12'h024, d, r);
      chk(d, 32'h0);
      $display("test reset done");
      end_sim();
   end
endmodule : tsm_slot_map_tb_top
`default_nettype wire
